// >>> verilog/flash_pin_front.sv
// What this block does
// - Deselected means all outputs high impedance.
// - Select falling edge leaves standby, starts sequence.
// - No instruction before a first select fall.
// - Lane inputs ignored while deselected.
// - Single lane input sampled on clock rise.
// - Single lane output changes on clock fall.
// - Dual and quad lanes: rise in, fall out.
// - Quad uses protect and pause pins as lanes.
// - Lock plus low protect pin refuses status writes.
// - Lock clear allows status writes always.
// - Quad enable disables the protect pin function.
// - Quad enable makes pause pin lane three.
// - Pause suspends transfer, keeps partial sequence.
// - Paused and selected keeps output high impedance.
// - Pause release continues where it stopped.
// - Optional reset pin low: reset, outputs off.
// - Only clock modes zero and three.
// - Quad peripheral mode uses four data lanes.
//
// Added by the designer: the plain strobed port and the placing of the registers.
module flash_pin_front
  import flash_pin_pkg::*;
#(
  parameter bit HW_RESET_OPT = 1'b0
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Serial link pins.
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] lane_i,
  output logic [3:0] lane_o,
  output logic [3:0] lane_oe_o,
  // Internal register port.
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Received byte stream.
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o
);

  logic sck_s; // Synchronised serial clock.
  logic cs_n_s; // Synchronised select.
  logic [3:0] lane_s; // Synchronised lanes.
  logic sck_prev_q; // Serial clock one cycle back.
  logic cs_seen_q; // Synchronised select one cycle back, high at idle.
  logic sck_rise_w;
  logic sck_fall_w;
  logic cs_fall_w;
  link_state_t state_q; // Link state.
  link_state_t state_d;
  logic [7:0] ctrl_q; // Lane mode, output phase, quad peripheral mode.
  logic [7:0] status_q; // Lock, quad enable and protect levels.
  logic [7:0] tx_q; // Next byte to send.
  logic tx_pend_q; // A byte waits to be sent.
  logic rx_pend_q; // A received byte waits to be read.
  logic [3:0] oe_d;
  logic [7:0] state_view_w;
  logic [7:0] rdata_d;
  logic qe_w;
  logic qpi_w;
  logic pin_fn_w;
  logic pause_w;
  logic hwrst_w;
  logic wp_block_w;
  logic status_wr_w;
  logic active_w;
  logic sample_w;
  logic drive_w;
  logic clear_w;
  logic tx_take_w;
  lane_mode_t req_mode_w;
  lane_mode_t mode_w;
  logic [3:0] mask_w;

  // All pins pass two flip-flops; idle levels are high.
  pin_sync2 #(.W(6), .RST(6'h3f)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({sck_i, cs_n_i, lane_i}),
    .q_o({sck_s, cs_n_s, lane_s})
  );

  // Edge finding on the sampled serial clock works in modes 0 and 3 alike.
  assign sck_rise_w = sck_s && !sck_prev_q;
  assign sck_fall_w = !sck_s && sck_prev_q;
  assign cs_fall_w = cs_seen_q && !cs_n_s;

  // Pin functions of the protect and pause pins.
  assign qe_w = status_q[ST_QE_BIT];
  assign qpi_w = ctrl_q[CTRL_QPI_BIT];
  assign pin_fn_w = !qe_w && !qpi_w;
  assign pause_w = pin_fn_w && !HW_RESET_OPT && !lane_s[3];
  assign hwrst_w = pin_fn_w && HW_RESET_OPT && !lane_s[3];
  assign wp_block_w = status_q[ST_LOCK_BIT] && !lane_s[2] && pin_fn_w;
  assign status_wr_w = reg_wr_i && (reg_addr_i == REG_STATUS);

  // Lane mode; quad needs the quad enable bit or quad peripheral mode.
  assign req_mode_w = lane_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign mode_w = qpi_w ? LANE_QUAD :
                  ((req_mode_w == LANE_QUAD) && !qe_w) ? LANE_DUAL :
                  req_mode_w;
  assign mask_w = (mode_w == LANE_QUAD) ? MASK_QUAD :
                  (mode_w == LANE_DUAL) ? MASK_DUAL : MASK_SINGLE;

  // Only an active, unpaused link samples or drives.
  assign active_w = (state_q == ST_ACTIVE);
  assign sample_w = active_w && sck_rise_w;
  assign drive_w = active_w && sck_fall_w;
  // The sequence restarts on deselect or reset, never on pause.
  assign clear_w = (state_q == ST_IDLE) || (state_q == ST_RESET);

  // Link state: select, pause and optional reset.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cs_fall_w) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (cs_n_s) begin
          state_d = ST_IDLE;
        end else if (pause_w) begin
          state_d = ST_PAUSED;
        end
      end
      ST_PAUSED: begin
        if (cs_n_s) begin
          state_d = ST_IDLE;
        end else if (!pause_w) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_RESET: begin
        if (!hwrst_w) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (hwrst_w) begin
      state_d = ST_RESET;
    end
  end

  // Lanes are enabled only while active and in the output phase.
  assign oe_d = (active_w && ctrl_q[CTRL_OUT_BIT]) ? mask_w : 4'h0;

  // State, edge history and output enables.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      sck_prev_q <= 1'b0;
      cs_seen_q <= 1'b0;
      lane_oe_o <= 4'h0;
    end else begin
      state_q <= state_d;
      sck_prev_q <= sck_s;
      cs_seen_q <= cs_n_s;
      lane_oe_o <= oe_d;
    end
  end

  // Serial byte shifting on the lanes.
  lane_shifter u_shift (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clear_i(clear_w),
    .mode_i(mode_w),
    .sample_i(sample_w),
    .drive_i(drive_w),
    .lanes_i(lane_s),
    .lanes_o(lane_o),
    .tx_byte_i(tx_q),
    .tx_take_o(tx_take_w),
    .rx_byte_o(rx_byte_o),
    .rx_done_o(rx_valid_o)
  );

  // Register writes; status fields obey the protect pin.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      status_q <= STATUS_RST;
      tx_q <= 8'h00;
    end else begin
      if (reg_wr_i && (reg_addr_i == REG_CTRL)) begin
        ctrl_q <= reg_wdata_i;
      end
      if (status_wr_w && !wp_block_w) begin
        status_q <= reg_wdata_i & STATUS_MASK;
      end
      if (reg_wr_i && (reg_addr_i == REG_TX)) begin
        tx_q <= reg_wdata_i;
      end
    end
  end

  // Pending flags: a setting event wins over a clearing one.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_pend_q <= 1'b0;
      rx_pend_q <= 1'b0;
    end else begin
      if (reg_wr_i && (reg_addr_i == REG_TX)) begin
        tx_pend_q <= 1'b1;
      end else if (tx_take_w) begin
        tx_pend_q <= 1'b0;
      end
      if (rx_valid_o) begin
        rx_pend_q <= 1'b1;
      end else if (reg_rd_i && (reg_addr_i == REG_RX)) begin
        rx_pend_q <= 1'b0;
      end
    end
  end

  // Read view of the live link state.
  assign state_view_w = {1'b0, wp_block_w, rx_pend_q, tx_pend_q,
                         cs_seen_q, (state_q == ST_RESET),
                         (state_q == ST_PAUSED), active_w};
  assign rdata_d = (reg_addr_i == REG_CTRL) ? ctrl_q :
                   (reg_addr_i == REG_STATUS) ? status_q :
                   (reg_addr_i == REG_STATE) ? state_view_w :
                   (reg_addr_i == REG_RX) ? rx_byte_o :
                   (reg_addr_i == REG_TX) ? tx_q : 8'h00;

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_d : 8'h00;
    end
  end

  // Deselect turns every lane off two cycles after the sampled level.
  oe_deselect_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    cs_n_s |-> ##2 (lane_oe_o == 4'h0))
    else $error("lane driven while deselected");

  // Entering the active state from idle needs a sampled high-to-low select step.
  arm_first_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ((state_q == ST_ACTIVE) && $past(state_q == ST_IDLE))
    |-> ($past(cs_n_s, 2) && !$past(cs_n_s)))
    else $error("selected without a select fall");

  // A received byte follows a rising edge taken while active.
  rx_on_rise_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_valid_o |-> $past(sck_rise_w) && $past(state_q == ST_ACTIVE))
    else $error("byte received outside an active rising edge");

  // Lane data change only after a falling edge of the serial clock.
  lane_on_fall_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $changed(lane_o) |-> $past(sck_fall_w))
    else $error("lane data changed off a falling edge");

  // Pause keeps the data output lane off.
  pause_quiet_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == ST_PAUSED) |=> !lane_oe_o[1])
    else $error("output driven while paused");

  // A protected status write leaves the status unchanged.
  status_lock_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (status_wr_w && wp_block_w) |=> $stable(status_q))
    else $error("status changed while protected");

  // An unlocked or quad enabled status write always lands.
  status_open_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (status_wr_w && (!status_q[ST_LOCK_BIT] || qe_w))
    |=> (status_q == ($past(reg_wdata_i) & STATUS_MASK)))
    else $error("allowed status write lost");

  // Hardware reset state keeps all lanes off.
  reset_quiet_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_q == ST_RESET) |=> (lane_oe_o == 4'h0))
    else $error("lane driven during hardware reset");

endmodule

// >>> verilog/flash_pin_pkg.sv
package flash_pin_pkg;

  // Register indices on the internal register port.
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_STATE = 3'h2;
  localparam logic [2:0] REG_RX = 3'h3;
  localparam logic [2:0] REG_TX = 3'h4;

  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OUT_BIT = 2;
  localparam int CTRL_QPI_BIT = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Status register fields: lock, quad enable and four protect levels.
  localparam int ST_LOCK_BIT = 7;
  localparam int ST_QE_BIT = 6;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] STATUS_MASK = 8'hfc;

  // Live state register fields.
  localparam int SV_SEL_BIT = 0;
  localparam int SV_PAUSE_BIT = 1;
  localparam int SV_RESET_BIT = 2;
  localparam int SV_ARMED_BIT = 3;
  localparam int SV_TXPEND_BIT = 4;
  localparam int SV_RXVAL_BIT = 5;
  localparam int SV_WPBLK_BIT = 6;

  // Lane counting and output enable masks.
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] STEP_1 = 4'h1;
  localparam logic [3:0] STEP_2 = 4'h2;
  localparam logic [3:0] STEP_4 = 4'h4;
  localparam logic [3:0] MASK_SINGLE = 4'h2;
  localparam logic [3:0] MASK_DUAL = 4'h3;
  localparam logic [3:0] MASK_QUAD = 4'hf;

  // Lane widths of a transfer.
  typedef enum logic [1:0] {
    LANE_SINGLE = 2'b00,
    LANE_DUAL = 2'b01,
    LANE_QUAD = 2'b10
  } lane_mode_t;

  // Link states as seen from the pins.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_PAUSED = 2'b10,
    ST_RESET = 2'b11
  } link_state_t;

endpackage

// >>> verilog/pin_sync2.sv
// Two flip-flop synchroniser for a group of pin levels.
module pin_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // The first stage is read only by the second stage.
  logic [W-1:0] meta_q;

  // Both stages reset to the idle level of the pins.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST;
      q_o <= RST;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

// >>> verilog/lane_shifter.sv
// Byte shifter for one, two or four lanes, sampled and driven on strobes.
module lane_shifter
  import flash_pin_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Sequence control.
  input wire logic clear_i,
  input wire lane_mode_t mode_i,
  input wire logic sample_i,
  input wire logic drive_i,
  // Lane data.
  input wire logic [3:0] lanes_i,
  output logic [3:0] lanes_o,
  // Byte side.
  input wire logic [7:0] tx_byte_i,
  output logic tx_take_o,
  output logic [7:0] rx_byte_o,
  output logic rx_done_o
);

  logic [3:0] step_w; // Bits moved per clock edge.
  logic [7:0] rx_sr_q; // Partly received byte.
  logic [3:0] rx_cnt_q; // Bits received so far.
  logic [3:0] rx_sum_w;
  logic [7:0] rx_shift_w;
  logic [7:0] tx_sr_q; // Byte being sent.
  logic [3:0] tx_cnt_q; // Bits sent so far.
  logic [3:0] tx_sum_w;
  logic [7:0] tx_shift_w;
  logic [7:0] tx_next_w;
  logic [3:0] tx_map_w;

  assign step_w = (mode_i == LANE_QUAD) ? STEP_4 :
                  (mode_i == LANE_DUAL) ? STEP_2 : STEP_1;
  assign rx_sum_w = rx_cnt_q + step_w;
  assign rx_shift_w = (mode_i == LANE_QUAD) ? {rx_sr_q[3:0], lanes_i} :
                      (mode_i == LANE_DUAL) ? {rx_sr_q[5:0], lanes_i[1:0]} :
                      {rx_sr_q[6:0], lanes_i[0]};
  assign tx_sum_w = tx_cnt_q + step_w;
  assign tx_shift_w = (mode_i == LANE_QUAD) ? {tx_sr_q[3:0], 4'h0} :
                      (mode_i == LANE_DUAL) ? {tx_sr_q[5:0], 2'b00} :
                      {tx_sr_q[6:0], 1'b0};
  // A new byte is taken at the first drive edge of each byte.
  assign tx_take_o = drive_i && (tx_cnt_q == 4'h0);
  assign tx_next_w = (tx_cnt_q == 4'h0) ? tx_byte_i : tx_shift_w;
  // Most significant bits first; single lane drives lane 1 only.
  assign tx_map_w = (mode_i == LANE_QUAD) ? tx_next_w[7:4] :
                    (mode_i == LANE_DUAL) ? {2'b00, tx_next_w[7:6]} :
                    {2'b00, tx_next_w[7], 1'b0};

  // Receive side: shift on each sample strobe, report whole bytes.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sr_q <= 8'h00;
      rx_cnt_q <= 4'h0;
      rx_byte_o <= 8'h00;
      rx_done_o <= 1'b0;
    end else if (clear_i) begin
      rx_cnt_q <= 4'h0;
      rx_done_o <= 1'b0;
    end else begin
      rx_done_o <= sample_i && (rx_sum_w == BYTE_BITS);
      if (sample_i) begin
        rx_sr_q <= rx_shift_w;
        rx_cnt_q <= (rx_sum_w == BYTE_BITS) ? 4'h0 : rx_sum_w;
        if (rx_sum_w == BYTE_BITS) begin
          rx_byte_o <= rx_shift_w;
        end
      end
    end
  end

  // Transmit side: lanes change only on a drive strobe.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sr_q <= 8'h00;
      tx_cnt_q <= 4'h0;
      lanes_o <= 4'h0;
    end else if (clear_i) begin
      tx_cnt_q <= 4'h0;
    end else if (drive_i) begin
      tx_sr_q <= tx_next_w;
      lanes_o <= tx_map_w;
      tx_cnt_q <= (tx_sum_w == BYTE_BITS) ? 4'h0 : tx_sum_w;
    end
  end

endmodule

// >>> bench/spi_host_model.sv
// Host side of the serial link: clock, select and the host's lane drivers.
module spi_host_model (
  // Clock.
  input wire logic sys_clk_i,
  // Device lane levels and enables.
  input wire logic [3:0] dev_lane_i,
  input wire logic [3:0] dev_oe_i,
  // Pins toward the device.
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] lane_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] drv_d; // Host lane data.
  logic [3:0] drv_oe; // Host lane enables.
  logic wp_lvl; // Protect pin level when not a lane.
  logic hold_lvl; // Pause pin level when not a lane.
  logic idle_pat; // Toggles so an undriven lane never looks stable.
  logic [3:0] pause_oe; // Device enables seen while paused.
  logic [7:0] cap; // Bits read back from the device.

  // Idle in clock mode 3, deselected, pause and reset pin high.
  initial begin
    sck_o = 1'b1;
    cs_n_o = 1'b1;
    drv_d = 4'h0;
    drv_oe = 4'h0;
    wp_lvl = 1'b1;
    hold_lvl = 1'b1;
    idle_pat = 1'b0;
    pause_oe = 4'h0;
    cap = 8'h00;
  end

  // Noise source for lanes that nobody drives.
  always @(posedge sys_clk_i) begin
    idle_pat <= ~idle_pat;
  end

  // Wire level: device first, then host, then board level or noise.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (dev_oe_i[k]) lane_o[k] = dev_lane_i[k];
      else if (drv_oe[k]) lane_o[k] = drv_d[k];
      else if (k == 2) lane_o[k] = wp_lvl;
      else if (k == 3) lane_o[k] = hold_lvl;
      else lane_o[k] = idle_pat;
    end
  end

  // Waits a number of system clock cycles.
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // Select falls before any instruction is sent.
  task automatic select();
    cs_n_o <= 1'b0;
    wait_n(8);
  endtask

  // Select rises and the host lets go of its lanes.
  task automatic deselect();
    cs_n_o <= 1'b1;
    drv_oe <= 4'h0;
    wait_n(8);
  endtask

  // One byte, MSB first, w lanes; data changes on fall, read on high phase.
  task automatic xfer(input logic [7:0] tx, input int w, input bit dev_out,
                      input int pause_at);
    logic [3:0] m;
    logic [3:0] bits;
    m = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hf;
    for (int i = 0; i < 8 / w; i++) begin
      // Pause mid-byte; clock edges meanwhile must be ignored.
      if (i == pause_at) begin
        hold_lvl <= 1'b0;
        wait_n(8);
        sck_o <= 1'b0;
        wait_n(4);
        sck_o <= 1'b1;
        wait_n(4);
        pause_oe = dev_oe_i;
        hold_lvl <= 1'b1;
        wait_n(8);
      end
      sck_o <= 1'b0;
      drv_oe <= dev_out ? ((w == 1) ? 4'h1 : 4'h0) : m;
      drv_d <= 4'(tx >> (8 - w * (i + 1))) & m;
      wait_n(4);
      sck_o <= 1'b1;
      wait_n(4);
      bits = (w == 1) ? {3'h0, lane_o[1]} : (lane_o & m);
      cap = 8'(cap << w) | 8'(bits);
    end
  endtask
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the flash pin front end.
module testbench
  import flash_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0; // System clock, 40 ns.
  logic rst_n; // Active low reset.
  logic sck; // Serial clock from the host.
  logic cs_n; // Select from the host.
  logic [3:0] lane_in; // Resolved lane levels.
  logic [3:0] lane_out; // Device lane data.
  logic [3:0] lane_oe; // Device lane enables.
  logic [2:0] reg_addr; // Register index.
  logic [7:0] reg_wdata; // Register write data.
  logic reg_wr; // Write strobe.
  logic reg_rd; // Read strobe.
  logic [7:0] reg_rdata; // Read data.
  logic [7:0] rx_byte; // Last received byte.
  logic rx_valid; // New byte pulse.
  int n_fail; // Mismatches.
  int num_checks; // Comparisons.
  int rx_cnt; // Received byte pulses.
  int base; // Byte count at transfer start.
  logic [7:0] rd; // Last register read.

  // Clock.
  always #20 sys_clk = ~sys_clk;

  // Counts received byte pulses.
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;
  end

  flash_pin_front #(.HW_RESET_OPT(1'b0)) flash_pin_front_i (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n),
    .lane_i(lane_in), .lane_o(lane_out), .lane_oe_o(lane_oe),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .rx_byte_o(rx_byte),
    .rx_valid_o(rx_valid)
  );

  spi_host_model spi_host_model_i (
    .sys_clk_i(sys_clk), .dev_lane_i(lane_out), .dev_oe_i(lane_oe),
    .sck_o(sck), .cs_n_o(cs_n), .lane_o(lane_in)
  );

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Waits a number of clock cycles.
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One write cycle.
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // One read cycle; data stands in the following cycle only.
  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  // Selected byte transfer with enable and byte count checks.
  task automatic one_byte(input logic [7:0] tx, input int w, input bit out,
                          input int p, input logic [3:0] exp_oe);
    base = rx_cnt;
    spi_host_model_i.select();
    spi_host_model_i.xfer(tx, w, out, p);
    wait_n(8);
    check(8'(lane_oe), 8'(exp_oe), "enables in transfer");
    spi_host_model_i.deselect();
    check(8'(lane_oe), 8'h00, "enables after deselect");
    check(8'(rx_cnt - base), 8'h01, "byte count");
  endtask

  // Reset values, unmapped read, idle enables.
  task automatic t_reset();
    reg_read(REG_CTRL, rd);
    check(rd, CTRL_RST, "control reset");
    reg_read(REG_STATUS, rd);
    check(rd, STATUS_RST, "status reset");
    reg_read(3'h5, rd);
    check(rd, 8'h00, "unmapped read");
    check(8'(lane_oe), 8'h00, "enables deselected");
  endtask

  // Clocking with select high before any select fall is ignored.
  task automatic t_ignored();
    base = rx_cnt;
    spi_host_model_i.xfer(8'hff, 1, 1'b0, 99);
    wait_n(8);
    check(8'(rx_cnt - base), 8'h00, "byte while deselected");
    check(8'(lane_oe), 8'h00, "enables deselected");
    spi_host_model_i.deselect();
  endtask

  // Single lane byte in both directions.
  task automatic t_single();
    reg_write(REG_CTRL, 8'h04);
    reg_write(REG_TX, 8'ha5);
    one_byte(8'h3c, 1, 1'b1, 99, MASK_SINGLE);
    check(rx_byte, 8'h3c, "single receive");
    check(spi_host_model_i.cap, 8'ha5, "single send");
    // Idle link, select seen high, one received byte pending.
    reg_read(REG_STATE, rd);
    check(rd, 8'h28, "state after byte");
    reg_read(REG_RX, rd);
    check(rd, 8'h3c, "byte read back");
    // Reading the byte clears its pending flag.
    reg_read(REG_STATE, rd);
    check(rd, 8'h08, "state after read");
  endtask

  // Pause in mid-byte, clock toggled meanwhile, then resume.
  task automatic t_pause();
    reg_write(REG_TX, 8'h5a);
    one_byte(8'h96, 1, 1'b1, 3, MASK_SINGLE);
    check(rx_byte, 8'h96, "receive across pause");
    check(spi_host_model_i.cap, 8'h5a, "send across pause");
    check(8'(spi_host_model_i.pause_oe), 8'h00, "paused output");
  endtask

  // One status write with the protect pin at a given level.
  task automatic status_try(input logic wp, input logic [7:0] d,
                            input logic [7:0] e);
    spi_host_model_i.wp_lvl <= wp;
    wait_n(4);
    reg_write(REG_STATUS, d);
    reg_read(REG_STATUS, rd);
    check(rd, e, "status write");
  endtask

  // Status write protection by lock bit, protect pin and quad enable.
  task automatic t_protect();
    status_try(1'b1, 8'h80, 8'h80);
    status_try(1'b0, 8'h3c, 8'h80);
    status_try(1'b1, 8'hbc, 8'hbc);
    status_try(1'b0, 8'h00, 8'hbc);
    status_try(1'b1, 8'h40, 8'h40);
    status_try(1'b0, 8'h7c, 8'h7c);
    status_try(1'b1, 8'hc0, 8'hc0);
    status_try(1'b0, 8'h40, 8'h40);
    spi_host_model_i.wp_lvl <= 1'b1;
  endtask

  // Each lane width in both directions, then quad peripheral mode.
  task automatic t_lanes();
    logic [3:0] masks [3] = '{MASK_SINGLE, MASK_DUAL, MASK_QUAD};
    int ws [3] = '{1, 2, 4};
    for (int m = 0; m < 3; m++) begin
      reg_write(REG_CTRL, 8'(m));
      one_byte(8'h1e + 8'(m), ws[m], 1'b0, 99, 4'h0);
      check(rx_byte, 8'h1e + 8'(m), "lane receive");
      reg_write(REG_CTRL, 8'(m) | 8'h04);
      reg_write(REG_TX, 8'hc3 ^ 8'(m));
      one_byte(8'h00, ws[m], 1'b1, 99, masks[m]);
      check(spi_host_model_i.cap, 8'hc3 ^ 8'(m), "lane send");
    end
    reg_write(REG_CTRL, 8'h08);
    one_byte(8'h7b, 4, 1'b0, 99, 4'h0);
    check(rx_byte, 8'h7b, "quad peripheral receive");
  endtask

  // Clock mode 0: the serial clock idles low before the frame.
  task automatic t_mode0();
    reg_write(REG_CTRL, 8'h00);
    spi_host_model_i.sck_o <= 1'b0;
    wait_n(8);
    one_byte(8'h69, 1, 1'b0, 99, 4'h0);
    check(rx_byte, 8'h69, "mode 0 receive");
  endtask

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_fail = 0;
    num_checks = 0;
    rx_cnt = 0;
    wait_n(20);
    rst_n <= 1'b1;
    wait_n(4);
    t_reset();
    t_ignored();
    t_single();
    t_pause();
    t_protect();
    t_lanes();
    t_mode0();
    give_verdict();
  end

  // Run limit: a hang counts as a mismatch.
  initial begin
    wait_n(40000);
    n_fail++;
    $display("[ERR] t=%0t run time limit reached", $time);
    give_verdict();
  end
endmodule
